//--- bench/lcdsd_panel_model.sv
module lcdsd_panel_model (
   // Panel pins
   input wire logic [7:0] seg_drive,
   input wire logic [7:0] oe_n,
   input wire logic [7:0] is_bp,
   // Frontplanes seen lit
   output logic [7:0] lit
);
   // ----------------------------------------
   // Glass model
   // ----------------------------------------
   logic bp_on;
   always_comb begin
      bp_on = |(seg_drive & is_bp & ~oe_n);
      lit = seg_drive & ~is_bp & ~oe_n & {8{bp_on}};
   end
endmodule

//--- bench/lcdsd_top_tb_top.sv
`include "lcdsd_cfg.svh"

module lcdsd_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic xtal = 1'b0;
   logic alt = 1'b0;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [7:0] seg_drive_q;
   logic [7:0] pin_oe_n_q;
   logic [7:0] pin_is_bp_q;
   logic [2:0] phase_out_q;
   logic lcd_irq_q;
   logic [7:0] lit;
   logic [7:0] wf [8];
   logic [31:0] rd;
   logic err;
   int failures = 0;
   int checked = 0;

   always #50 pclk = ~pclk;
   always #200 xtal = ~xtal;
   always #330 alt = ~alt;

   lcdsd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
      .pready_q(pready_q), .pslverr_q(pslverr_q), .xtal_clk_in(xtal), .alt_clk_in(alt),
      .seg_drive_q(seg_drive_q), .pin_oe_n_q(pin_oe_n_q), .pin_is_bp_q(pin_is_bp_q),
      .phase_out_q(phase_out_q), .lcd_irq_q(lcd_irq_q));

   lcdsd_panel_model panel (.seg_drive(seg_drive_q), .oe_n(pin_oe_n_q),
      .is_bp(pin_is_bp_q), .lit(lit));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task complete_run;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready_q !== 1'b1 && n < 20);
      if (n >= 20) begin
         check("pready_q", 1, 0);
         complete_run();
      end
      rd = prdata_q;
      err = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, exp, rd);
   endtask

   function automatic logic [7:0] exp_seg(input int ph);
      for (int i = 0; i < 8; i++) begin
         exp_seg[i] = wf[i][ph];
      end
   endfunction

   // Wait for a phase, or for blank (2) or alternate (1) output
   task wait_for(input int kind, input int ph, input int lim);
      int n;
      n = 0;
      while (n < lim && !((kind == 0 && phase_out_q === ph[2:0])
            || (kind == 1 && phase_out_q[2] === 1'b1)
            || (kind == 2 && seg_drive_q === 8'h00))) begin
         @(posedge pclk);
         n++;
      end
      if (n >= lim) begin
         check("wait limit", 1, 0);
         complete_run();
      end
      repeat (2) @(posedge pclk);
   endtask

   task run_phases(input int base, input int last);
      for (int p = 0; p <= last; p++) begin
         wait_for(0, base + p, 2000);
         check("seg_drive_q", exp_seg(base + p), seg_drive_q);
      end
   endtask

   // Length of one alternate half in pclk cycles
   task half_len(input logic [2:0] rate);
      int n;
      apb(1'b1, `LCDSD_OFF_BLINK, 32'h0);
      apb(1'b1, `LCDSD_OFF_BLINK, {24'h0, 5'b10001, rate});
      wait_for(1, 0, 40000);
      n = 2;
      while (phase_out_q[2] === 1'b1 && n < 40000) begin
         @(posedge pclk);
         n++;
      end
      check("blink half in range", 1, (n > (8192 << rate) - 60) && (n < (8192 << rate) + 60));
   endtask

   // Length of phase B in pclk cycles
   task phase_len(input int lo, input int hi);
      int n;
      wait_for(0, 1, 2000);
      n = 2;
      while (phase_out_q === 3'h1 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      check("phase length in range", 1, (n > lo) && (n < hi));
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      wf = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h05, 8'h30, 8'hC3, 8'h5A};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      check("pin_oe_n_q", 8'hFF, pin_oe_n_q);
      check("lcd_irq_q", 0, lcd_irq_q);
      rchk("ctrl0", `LCDSD_OFF_CTRL0, 32'h03);
      rchk("ctrl1", `LCDSD_OFF_CTRL1, 32'h10);
      rchk("blink", `LCDSD_OFF_BLINK, 32'h00);
      rchk("status", `LCDSD_OFF_STATUS, 32'h00);
      apb(1'b0, 8'h18, 32'h0);
      check("pslverr_q", 1, err);
      check("unmapped read data", 0, rd);
      $display("test reset done");

      apb(1'b1, `LCDSD_OFF_CTRL0, 32'h03);
      apb(1'b1, `LCDSD_OFF_CTRL1, 32'h80);
      apb(1'b1, `LCDSD_OFF_BLINK, 32'h00);
      apb(1'b1, `LCDSD_OFF_PEN, 32'hFF);
      apb(1'b1, `LCDSD_OFF_BPEN, 32'h0F);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, `LCDSD_OFF_WF0 + 8'(4 * i), {24'h0, wf[i]});
      end
      apb(1'b1, `LCDSD_OFF_CTRL0, 32'h83);
      run_phases(0, 3);
      check("lit", exp_seg(3) & 8'hF0, lit);
      check("pin_oe_n_q", 8'h00, pin_oe_n_q);
      check("pin_is_bp_q", 8'h0F, pin_is_bp_q);
      wait_for(0, 0, 2000);
      rchk("frame flag", `LCDSD_OFF_STATUS, 32'h80);
      check("lcd_irq_q", 1, lcd_irq_q);
      apb(1'b1, `LCDSD_OFF_STATUS, 32'h80);
      apb(1'b0, `LCDSD_OFF_STATUS, 32'h0);
      check("frame flag cleared", 0, rd[7]);
      check("lcd_irq_q", 0, lcd_irq_q);
      $display("test normal done");

      apb(1'b1, `LCDSD_OFF_BLINK, 32'h40);
      run_phases(4, 3);
      apb(1'b1, `LCDSD_OFF_BLINK, 32'h20);
      repeat (40) @(posedge pclk);
      check("blank seg_drive_q", 0, seg_drive_q);
      check("blank lit", 0, lit);
      $display("test alternate and blank done");

      apb(1'b1, `LCDSD_OFF_BPEN, 32'hFF);
      apb(1'b1, `LCDSD_OFF_BLINK, 32'h00);
      apb(1'b1, `LCDSD_OFF_CTRL0, 32'h87);
      run_phases(0, 7);
      apb(1'b1, `LCDSD_OFF_BLINK, 32'h40);
      repeat (40) @(posedge pclk);
      check("duty8 alt seg_drive_q", 0, seg_drive_q);
      apb(1'b1, `LCDSD_OFF_BLINK, 32'h88);
      wait_for(2, 0, 20000);
      $display("test eight phases done");

      apb(1'b1, `LCDSD_OFF_BPEN, 32'h0F);
      apb(1'b1, `LCDSD_OFF_CTRL0, 32'h03);
      apb(1'b1, `LCDSD_OFF_CTRL0, 32'h83);
      half_len(3'h0);
      half_len(3'h1);
      apb(1'b1, `LCDSD_OFF_BLINK, 32'h00);
      apb(1'b1, `LCDSD_OFF_BLINK, 32'h80);
      wait_for(2, 0, 20000);
      apb(1'b1, `LCDSD_OFF_BLINK, 32'h00);
      apb(1'b1, `LCDSD_OFF_BLINK, 32'hA8);
      repeat (40) @(posedge pclk);
      check("blank normal half", 0, seg_drive_q);
      wait_for(1, 0, 20000);
      $display("test blink done");

      apb(1'b1, `LCDSD_OFF_BLINK, 32'h00);
      apb(1'b1, `LCDSD_OFF_CTRL0, 32'h03);
      apb(1'b1, `LCDSD_OFF_CTRL0, 32'hCB);
      phase_len(60, 72);
      $display("test alternate clock done");

      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check("pin_oe_n_q", 8'hFF, pin_oe_n_q);
      check("seg_drive_q", 0, seg_drive_q);
      presetn <= 1'b1;
      rchk("ctrl0", `LCDSD_OFF_CTRL0, 32'h03);
      rchk("blink", `LCDSD_OFF_BLINK, 32'h00);
      $display("test second reset done");
      complete_run();
   end
endmodule

//--- design/lcdsd_cfg.svh
`ifndef LCDSD_CFG_SVH
`define LCDSD_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LCDSD_OFF_CTRL0 8'h00
`define LCDSD_OFF_CTRL1 8'h04
`define LCDSD_OFF_BLINK 8'h08
`define LCDSD_OFF_STATUS 8'h0C
`define LCDSD_OFF_PEN 8'h10
`define LCDSD_OFF_BPEN 8'h14
`define LCDSD_OFF_WF0 8'h20
`define LCDSD_OFF_WF7 8'h3C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCDSD_C0_EN 7
`define LCDSD_C0_SOURCE 6
`define LCDSD_C0_FRAME_CLOCK_SEL_LSB 3
`define LCDSD_C0_DUTY_LSB 0
`define LCDSD_C1_IRQEN 7
`define LCDSD_C1_BIAS 4
`define LCDSD_C1_SUPPLY_LSB 2
`define LCDSD_C1_STOP 1
`define LCDSD_C1_WAIT 0
`define LCDSD_BC_BLINK 7
`define LCDSD_BC_ALT 6
`define LCDSD_BC_BLANK 5
`define LCDSD_BC_BLINK_MODE_SEL 3
`define LCDSD_BC_BLINK_RATE_FIELD_LSB 0
`define LCDSD_ST_FLAG 7
`define LCDSD_ST_BLINKPER 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCDSD_DUTY_RST 3'h3
`define LCDSD_FRAME_CLOCK_SEL_RST 3'h0
`define LCDSD_SUPPLY_RST 2'h0
`define LCDSD_BLINK_RATE_FIELD_RST 3'h0

// ----------------------------------------
// Timing counts, in LCD clock ticks
// ----------------------------------------
`define LCDSD_FRAME_DIV_BASE 5'h08
`define LCDSD_BLINK_SHIFT 5'h0B
`define LCDSD_BLINK_CNT_W 19

`endif

//--- design/lcdsd_phase_gen.sv
`include "lcdsd_cfg.svh"

module lcdsd_phase_gen (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic run,
   input wire logic lcd_tick,
   input wire logic [2:0] duty,
   input wire logic [2:0] frame_clock_sel,
   // Sequence
   output logic [2:0] phase_q,
   output logic frame_done
);

   logic [4:0] div_q;
   logic [4:0] div_top;
   logic step;

   assign div_top = `LCDSD_FRAME_DIV_BASE + {2'h0, frame_clock_sel};
   assign step = run && lcd_tick && (div_q >= div_top);
   assign frame_done = step && (phase_q >= duty);

   // ----------------------------------------
   // Base clock divider
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 5'h00;
      end else if (!run || step) begin
         div_q <= 5'h00;
      end else if (lcd_tick) begin
         div_q <= div_q + 5'h01;
      end
   end

   // ----------------------------------------
   // Phase sequencer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q <= 3'h0;
      end else if (!run || frame_done) begin
         phase_q <= 3'h0;
      end else if (step) begin
         phase_q <= phase_q + 3'h1;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_phase_bound: assert property (phase_q <= duty)
      else $error("phase beyond duty");
   a_frame_wrap: assert property (frame_done |=> phase_q == 3'h0)
      else $error("phase not restarted after frame");

endmodule

//--- design/lcdsd_pkg.sv
package lcdsd_pkg;

   // Display mode, one-hot
   typedef enum logic [2:0] {
      LCDSD_DISP_NORMAL = 3'b001,
      LCDSD_DISP_ALT = 3'b010,
      LCDSD_DISP_BLANK = 3'b100
   } lcdsd_disp_t;

endpackage

//--- design/lcdsd_top.sv
// What this block does
// - Backplane waveform bit n selects phase A..H
// - Frontplane bit one drives on, zero off
// - Duty sets number of phases per frame
// - Normal mode drives waveform register data
// - Blank mode turns every segment off
// - Alternate uses phases E..H for duty up to four
// - Alternate with five+ backplanes gives blank
// - Blink period uses blank or alternate per mode
// - Five+ backplanes: blink mode one means blank
// - Blank select: normal blank, blink by mode
// - Alternate select: normal alternate, blink by mode
// - Blink rate divides LCD clock, halves per code
// - Reset clears enable, all pins high impedance
// - Reset gives duty 1/4, bias 1/3, defaults
// - Frame event sets flag, write one clears
// - Interrupt when flag and enable both set
// - Duty field value plus one is backplane count
// - Source zero crystal, one alternate clock
//
// The APB register port and the placing of the registers are this design's own decisions.
`include "lcdsd_cfg.svh"

module lcdsd_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_q,
   output logic pready_q,
   output logic pslverr_q,
   // LCD clock sources
   input wire logic xtal_clk_in,
   input wire logic alt_clk_in,
   // Panel pins
   output logic [7:0] seg_drive_q,
   output logic [7:0] pin_oe_n_q,
   output logic [7:0] pin_is_bp_q,
   output logic [2:0] phase_out_q,
   // Interrupt
   output logic lcd_irq_q
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic module_en_q;
   logic source_q;
   logic [2:0] frame_clock_sel_q;
   logic [2:0] duty_q;
   logic irq_en_q;
   logic [1:0] supply_q;
   logic stop_beh_q;
   logic wait_beh_q;
   logic blink_en_q;
   logic alt_sel_q;
   logic blank_sel_q;
   logic blink_mode_sel_q;
   logic [2:0] blink_rate_field_q;
   logic frame_flag_q;
   logic [7:0] pen_q;
   logic [7:0] bpen_q;
   logic [7:0] wf_q [0:7];
   logic xtal_s1_q;
   logic xtal_s2_q;
   logic alt_s1_q;
   logic alt_s2_q;
   logic lcd_prev_q;
   logic lcd_sel;
   logic lcd_tick;
   logic [`LCDSD_BLINK_CNT_W-1:0] blink_cnt_q;
   logic blink_period;
   logic [2:0] phase;
   logic frame_done;
   logic setup;
   logic wr;
   logic mapped;
   logic [31:0] rdata_d;
   lcdsd_pkg::lcdsd_disp_t mode;
   logic [2:0] phase_sel;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic is_wf(input logic [7:0] a);
      is_wf = (a >= `LCDSD_OFF_WF0) && (a <= `LCDSD_OFF_WF7) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [2:0] wf_index(input logic [7:0] a);
      wf_index = 3'(a[4:2]);
   endfunction

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite && pready_q;
   assign mapped = (paddr == `LCDSD_OFF_CTRL0) || (paddr == `LCDSD_OFF_CTRL1) ||
                   (paddr == `LCDSD_OFF_BLINK) || (paddr == `LCDSD_OFF_STATUS) ||
                   (paddr == `LCDSD_OFF_PEN) || (paddr == `LCDSD_OFF_BPEN) ||
                   is_wf(paddr);

   always_comb begin
      rdata_d = 32'h0000_0000;
      case (paddr)
         `LCDSD_OFF_CTRL0: begin
            rdata_d[`LCDSD_C0_EN] = module_en_q;
            rdata_d[`LCDSD_C0_SOURCE] = source_q;
            rdata_d[`LCDSD_C0_FRAME_CLOCK_SEL_LSB +: 3] = frame_clock_sel_q;
            rdata_d[`LCDSD_C0_DUTY_LSB +: 3] = duty_q;
         end
         `LCDSD_OFF_CTRL1: begin
            rdata_d[`LCDSD_C1_IRQEN] = irq_en_q;
            rdata_d[`LCDSD_C1_BIAS] = 1'b1;
            rdata_d[`LCDSD_C1_SUPPLY_LSB +: 2] = supply_q;
            rdata_d[`LCDSD_C1_STOP] = stop_beh_q;
            rdata_d[`LCDSD_C1_WAIT] = wait_beh_q;
         end
         `LCDSD_OFF_BLINK: begin
            rdata_d[`LCDSD_BC_BLINK] = blink_en_q;
            rdata_d[`LCDSD_BC_ALT] = alt_sel_q;
            rdata_d[`LCDSD_BC_BLANK] = blank_sel_q;
            rdata_d[`LCDSD_BC_BLINK_MODE_SEL] = blink_mode_sel_q;
            rdata_d[`LCDSD_BC_BLINK_RATE_FIELD_LSB +: 3] = blink_rate_field_q;
         end
         `LCDSD_OFF_STATUS: begin
            rdata_d[`LCDSD_ST_FLAG] = frame_flag_q;
            rdata_d[`LCDSD_ST_BLINKPER] = blink_period;
         end
         `LCDSD_OFF_PEN: begin
            rdata_d[7:0] = pen_q;
         end
         `LCDSD_OFF_BPEN: begin
            rdata_d[7:0] = bpen_q;
         end
         default: begin
            if (is_wf(paddr)) begin
               rdata_d[7:0] = wf_q[wf_index(paddr)];
            end
         end
      endcase
   end

   // ----------------------------------------
   // APB answer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
         if (setup) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
         end
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         module_en_q <= 1'b0;
         source_q <= 1'b0;
         frame_clock_sel_q <= `LCDSD_FRAME_CLOCK_SEL_RST;
         duty_q <= `LCDSD_DUTY_RST;
         irq_en_q <= 1'b0;
         supply_q <= `LCDSD_SUPPLY_RST;
         stop_beh_q <= 1'b0;
         wait_beh_q <= 1'b0;
         blink_en_q <= 1'b0;
         alt_sel_q <= 1'b0;
         blank_sel_q <= 1'b0;
         blink_mode_sel_q <= 1'b0;
         blink_rate_field_q <= `LCDSD_BLINK_RATE_FIELD_RST;
      end else if (wr && !pslverr_q) begin
         if (paddr == `LCDSD_OFF_CTRL0) begin
            module_en_q <= pwdata[`LCDSD_C0_EN];
            source_q <= pwdata[`LCDSD_C0_SOURCE];
            frame_clock_sel_q <= pwdata[`LCDSD_C0_FRAME_CLOCK_SEL_LSB +: 3];
            duty_q <= pwdata[`LCDSD_C0_DUTY_LSB +: 3];
         end
         if (paddr == `LCDSD_OFF_CTRL1) begin
            irq_en_q <= pwdata[`LCDSD_C1_IRQEN];
            supply_q <= pwdata[`LCDSD_C1_SUPPLY_LSB +: 2];
            stop_beh_q <= pwdata[`LCDSD_C1_STOP];
            wait_beh_q <= pwdata[`LCDSD_C1_WAIT];
         end
         if (paddr == `LCDSD_OFF_BLINK) begin
            blink_en_q <= pwdata[`LCDSD_BC_BLINK];
            alt_sel_q <= pwdata[`LCDSD_BC_ALT];
            blank_sel_q <= pwdata[`LCDSD_BC_BLANK];
            blink_mode_sel_q <= pwdata[`LCDSD_BC_BLINK_MODE_SEL];
            blink_rate_field_q <= pwdata[`LCDSD_BC_BLINK_RATE_FIELD_LSB +: 3];
         end
      end
   end

   // ----------------------------------------
   // Pin and waveform registers, no reset
   // ----------------------------------------
   always_ff @(posedge pclk) begin
      if (wr && !pslverr_q) begin
         if (paddr == `LCDSD_OFF_PEN) begin
            pen_q <= pwdata[7:0];
         end
         if (paddr == `LCDSD_OFF_BPEN) begin
            bpen_q <= pwdata[7:0];
         end
         if (is_wf(paddr)) begin
            wf_q[wf_index(paddr)] <= pwdata[7:0];
         end
      end
   end

   // ----------------------------------------
   // Frame flag and interrupt
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_flag_q <= 1'b0;
      end else if (frame_done) begin
         frame_flag_q <= 1'b1;
      end else if (wr && !pslverr_q && paddr == `LCDSD_OFF_STATUS &&
                   pwdata[`LCDSD_ST_FLAG]) begin
         frame_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcd_irq_q <= 1'b0;
      end else begin
         lcd_irq_q <= frame_flag_q && irq_en_q;
      end
   end

   // ----------------------------------------
   // LCD clock source
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_s1_q <= 1'b0;
         xtal_s2_q <= 1'b0;
         alt_s1_q <= 1'b0;
         alt_s2_q <= 1'b0;
         lcd_prev_q <= 1'b0;
      end else begin
         xtal_s1_q <= xtal_clk_in;
         xtal_s2_q <= xtal_s1_q;
         alt_s1_q <= alt_clk_in;
         alt_s2_q <= alt_s1_q;
         lcd_prev_q <= lcd_sel;
      end
   end

   assign lcd_sel = source_q ? alt_s2_q : xtal_s2_q;
   assign lcd_tick = lcd_sel && !lcd_prev_q;

   // ----------------------------------------
   // Blink divider
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blink_cnt_q <= '0;
      end else if (!module_en_q || !blink_en_q) begin
         blink_cnt_q <= '0;
      end else if (lcd_tick) begin
         blink_cnt_q <= blink_cnt_q + 1'b1;
      end
   end

   // Top bit of the chosen divider: equal halves
   assign blink_period = blink_en_q &&
                         blink_cnt_q[`LCDSD_BLINK_SHIFT + {2'h0, blink_rate_field_q}];

   // ----------------------------------------
   // Phase generator
   // ----------------------------------------
   lcdsd_phase_gen u_phase (
      .pclk(pclk),
      .presetn(presetn),
      .run(module_en_q),
      .lcd_tick(lcd_tick),
      .duty(duty_q),
      .frame_clock_sel(frame_clock_sel_q),
      .phase_q(phase),
      .frame_done(frame_done)
   );

   // ----------------------------------------
   // Display mode selection
   // ----------------------------------------
   always_comb begin
      if (blink_period) begin
         if (blink_mode_sel_q && !duty_q[2]) begin
            mode = lcdsd_pkg::LCDSD_DISP_ALT;
         end else begin
            mode = lcdsd_pkg::LCDSD_DISP_BLANK;
         end
      end else if (blank_sel_q) begin
         mode = lcdsd_pkg::LCDSD_DISP_BLANK;
      end else if (alt_sel_q) begin
         mode = duty_q[2] ? lcdsd_pkg::LCDSD_DISP_BLANK :
                lcdsd_pkg::LCDSD_DISP_ALT;
      end else begin
         mode = lcdsd_pkg::LCDSD_DISP_NORMAL;
      end
   end

   assign phase_sel = (mode == lcdsd_pkg::LCDSD_DISP_ALT) ? {1'b1, phase[1:0]} : phase;

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seg_drive_q <= 8'h00;
         pin_oe_n_q <= 8'hFF;
         pin_is_bp_q <= 8'h00;
         phase_out_q <= 3'h0;
      end else begin
         phase_out_q <= phase_sel;
         for (int i = 0; i < 8; i++) begin
            pin_oe_n_q[i] <= !(module_en_q && pen_q[i]);
            pin_is_bp_q[i] <= module_en_q && bpen_q[i];
            case (mode)
               lcdsd_pkg::LCDSD_DISP_NORMAL,
               lcdsd_pkg::LCDSD_DISP_ALT: begin
                  // Backplane active, or segment on-level
                  seg_drive_q[i] <= module_en_q && wf_q[i][phase_sel];
               end
               lcdsd_pkg::LCDSD_DISP_BLANK: begin
                  seg_drive_q[i] <= 1'b0;
               end
               default: begin
                  seg_drive_q[i] <= 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_irq_follow_flag: assert property ((frame_flag_q && irq_en_q) |=> lcd_irq_q)
      else $error("irq missing");
   a_irq_no_cause: assert property (!(frame_flag_q && irq_en_q) |=> !lcd_irq_q)
      else $error("irq without cause");
   a_flag_set: assert property (frame_done |=> frame_flag_q)
      else $error("frame flag not set");
   a_flag_hold: assert property ((frame_flag_q && !wr) |=> frame_flag_q)
      else $error("frame flag lost");
   a_disabled_hiz: assert property (!module_en_q |=> pin_oe_n_q == 8'hFF)
      else $error("pin driven while disabled");
   a_blank_off: assert property ((mode == lcdsd_pkg::LCDSD_DISP_BLANK) |=> seg_drive_q == 8'h00)
      else $error("segment on in blank");
   a_large_no_alt: assert property (duty_q[2] |-> mode != lcdsd_pkg::LCDSD_DISP_ALT)
      else $error("alternate with many backplanes");
   a_blink_blank: assert property ((blink_period && !blink_mode_sel_q) |-> mode == lcdsd_pkg::LCDSD_DISP_BLANK)
      else $error("blink period not blank");
   a_alt_phase: assert property ((mode == lcdsd_pkg::LCDSD_DISP_ALT) |=> phase_out_q[2])
      else $error("alternate phase not E..H");
   a_bus_ready: assert property (setup |=> pready_q ##1 !pready_q)
      else $error("pready timing wrong");

endmodule
